// File: pldl_loader.sv
// Implementation choice: the Wishbone slave port.
`timescale 1ns/10ps
module pldl_loader (
    input  logic                      ref_clk_i,    // 25 MHz clock
    input  logic                      resetn_i,     // sync reset, low
    input  logic                      ce_i,         // clock enable
    input  logic                      wb_cyc_i,     // wishbone cycle
    input  logic                      wb_stb_i,     // wishbone strobe
    input  logic                      wb_we_i,      // write enable
    input  logic [7:0]                wb_adr_i,     // byte address
    input  logic [3:0]                wb_sel_i,     // byte selects
    input  logic [31:0]               wb_dat_i,     // write data
    output logic [31:0]               wb_dat_o,     // read data
    output logic                      wb_ack_o,     // acknowledge
    output logic [7:0]                nvm_addr_o,   // store word address
    output logic                      nvm_rd_o,     // store read pulse
    input  pldl_pkg::pldl_nvm_rsp_type nvm_rsp_i,   // store answer
    input  logic                      d3hot_to_d0_i, // power state change
    output logic                      soft_reset_o, // internal reset pulse
    output pldl_pkg::pldl_cfg_type    cfg_o,        // loaded defaults
    output logic                      load_done_o   // fields valid
);
    import pldl_pkg::*;

    // ==========================================================
    // state
    // ==========================================================
    pldl_state_type state_r;
    pldl_state_type state_nxt;
    logic [1:0]     idx_r;
    logic [1:0]     idx_nxt;
    logic [15:0]    words_r [0:2];
    logic [2:0]     err_r;
    logic [7:0]     tmo_r;
    logic           use_def_r;
    logic           done_r;
    pldl_cfg_type   cfg_r;
    pldl_cfg_type   dec_cfg;
    logic           nvm_rd_r;
    logic [7:0]     nvm_addr_r;
    logic           soft_rst_r;
    logic           ack_r;
    logic [31:0]    dat_r;

    // ==========================================================
    // helpers
    // ==========================================================
    function automatic logic [15:0] default_word(input logic [1:0] k);
        logic [15:0] w;
        case (k)
            2'h0:    w = DEF_INIT3;
            2'h1:    w = DEF_CTRL1;
            default: w = DEF_LED;
        endcase
        return w;
    endfunction

    function automatic logic [7:0] reg_addr(input logic [7:0] idx);
        return {idx[5:0], 2'b00};
    endfunction

    // ==========================================================
    // field decode
    // ==========================================================
    pldl_word_decode u_dec (
        .init3_i (words_r[0]),
        .ctrl1_i (words_r[1]),
        .led_i   (words_r[2]),
        .cfg_o   (dec_cfg)
    );

    // ==========================================================
    // loader conditions
    // ==========================================================
    wire in_req     = (state_r == ST_REQ);
    wire in_wait    = (state_r == ST_WAIT);
    wire in_done    = (state_r == ST_DONE);
    wire last_word  = (idx_r == LAST_WORD_IDX);

    wire rsp_take   = in_wait & nvm_rsp_i.valid;
    // a silent store must not hang the loader forever
    wire tmo_hit    = in_wait & ~nvm_rsp_i.valid & (tmo_r == NVM_TMO_CYCLES);
    wire skip_take  = in_req & use_def_r;
    wire word_end   = rsp_take | tmo_hit | skip_take;
    wire word_bad   = tmo_hit | (rsp_take & nvm_rsp_i.err);
    wire rsp_good   = rsp_take & ~nvm_rsp_i.err;

    wire [15:0] word_val = rsp_good ? nvm_rsp_i.data : default_word(idx_r);

    wire [7:0] word_addr = NVM_WORD_BASE + {6'h00, idx_r};

    // ==========================================================
    // register decode
    // ==========================================================
    wire wb_req     = wb_cyc_i & wb_stb_i & ~ack_r;
    wire hit_ctrl   = (wb_adr_i == reg_addr(IDX_CTRL));
    wire hit_status = (wb_adr_i == reg_addr(IDX_STATUS));
    wire hit_cfg    = (wb_adr_i == reg_addr(IDX_CFG_VIEW));
    wire hit_w0     = (wb_adr_i == reg_addr(IDX_INIT3));
    wire hit_w1     = (wb_adr_i == reg_addr(IDX_CTRL1));
    wire hit_w2     = (wb_adr_i == reg_addr(IDX_LED));

    // loaded values are held back until the load finishes
    wire gated_rd   = ~wb_we_i & (hit_cfg | hit_w0 | hit_w1 | hit_w2);
    wire wb_go      = wb_req & (~gated_rd | done_r);

    wire wr_ctrl    = wb_go & wb_we_i & hit_ctrl & wb_sel_i[0];
    // a reload while busy is dropped; the running load finishes first
    wire reload_req = wr_ctrl & wb_dat_i[CTRL_RELOAD_BIT] & in_done;

    wire [31:0] rd_ctrl   = {30'h0, use_def_r, 1'b0};
    wire [31:0] rd_status = {27'h0, err_r, ~done_r, done_r};
    wire [31:0] rd_cfg    = {5'h00, cfg_r};
    wire [31:0] rd_w0     = {16'h0000, words_r[0]};
    wire [31:0] rd_w1     = {16'h0000, words_r[1]};
    wire [31:0] rd_w2     = {16'h0000, words_r[2]};

    wire [31:0] rd_mux = hit_ctrl   ? rd_ctrl   :
                         hit_status ? rd_status :
                         hit_cfg    ? rd_cfg    :
                         hit_w0     ? rd_w0     :
                         hit_w1     ? rd_w1     :
                         hit_w2     ? rd_w2     :
                         32'h0000_0000;

    // ==========================================================
    // loader state machine
    // ==========================================================
    always_comb begin
        state_nxt = state_r;
        idx_nxt   = idx_r;
        case (state_r)
            ST_REQ: begin
                if (use_def_r) begin
                    if (last_word) begin
                        state_nxt = ST_DONE;
                    end else begin
                        idx_nxt = idx_r + 2'h1;
                    end
                end else begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (word_end) begin
                    if (last_word) begin
                        state_nxt = ST_DONE;
                    end else begin
                        idx_nxt   = idx_r + 2'h1;
                        state_nxt = ST_REQ;
                    end
                end
            end
            ST_DONE: begin
                if (reload_req) begin
                    state_nxt = ST_REQ;
                    idx_nxt   = 2'h0;
                end
            end
            default: begin
                state_nxt = ST_REQ;
                idx_nxt   = 2'h0;
            end
        endcase
    end

    // load starts straight out of reset
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            state_r <= ST_REQ;
            idx_r   <= 2'h0;
        end else if (ce_i) begin
            state_r <= state_nxt;
            idx_r   <= idx_nxt;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            tmo_r <= 8'h00;
        end else if (ce_i) begin
            tmo_r <= in_wait ? tmo_r + 8'h01 : 8'h00;
        end
    end

    // ==========================================================
    // store read port
    // ==========================================================
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            nvm_rd_r   <= 1'b0;
            nvm_addr_r <= NVM_WORD_BASE;
        end else if (ce_i) begin
            nvm_rd_r   <= in_req & ~use_def_r;
            nvm_addr_r <= word_addr;
        end
    end

    // ==========================================================
    // word buffer, one entry per stored word
    // ==========================================================
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_word
            always_ff @(posedge ref_clk_i) begin
                if (!resetn_i) begin
                    words_r[gi] <= default_word(2'(gi));
                    err_r[gi]   <= 1'b0;
                end else if (ce_i) begin
                    if (word_end && idx_r == 2'(gi)) begin
                        words_r[gi] <= word_val;
                        err_r[gi]   <= word_bad;
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // loaded fields
    // ==========================================================
    // all fields switch together so the host never sees a mix
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            cfg_r  <= CFG_RESET;
            done_r <= 1'b0;
        end else if (ce_i) begin
            if (in_done) begin
                cfg_r <= dec_cfg;
            end
            done_r <= in_done & ~reload_req;
        end
    end

    // capability version comes from the store as is; 10b there is needed
    // for the extended capability

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            soft_rst_r <= 1'b0;
        end else if (ce_i) begin
            soft_rst_r <= d3hot_to_d0_i & ~cfg_r.no_soft_reset;
        end
    end

    // ==========================================================
    // control register
    // ==========================================================
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            use_def_r <= 1'b0;
        end else if (ce_i) begin
            if (wr_ctrl) begin
                use_def_r <= wb_dat_i[CTRL_DEFAULTS_BIT];
            end
        end
    end

    // ==========================================================
    // wishbone answer
    // ==========================================================
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_r <= wb_go;
            dat_r <= (wb_go & ~wb_we_i) ? rd_mux : 32'h0000_0000;
        end
    end

    // ==========================================================
    // outputs
    // ==========================================================
    assign wb_ack_o     = ack_r;
    assign wb_dat_o     = dat_r;
    assign nvm_rd_o     = nvm_rd_r;
    assign nvm_addr_o   = nvm_addr_r;
    assign soft_reset_o = soft_rst_r;
    assign cfg_o        = cfg_r;
    assign load_done_o  = done_r;

endmodule

// File: pldl_pkg.sv
package pldl_pkg;

    // ==========================================================
    // store word addresses and register indices
    // ==========================================================
    localparam logic [7:0] NVM_WORD_BASE  = 8'h1A;
    localparam logic [1:0] LAST_WORD_IDX  = 2'h2;
    localparam logic [7:0] IDX_CTRL       = 8'h00;
    localparam logic [7:0] IDX_STATUS     = 8'h01;
    localparam logic [7:0] IDX_CFG_VIEW   = 8'h02;
    localparam logic [7:0] IDX_INIT3      = 8'h1A;
    localparam logic [7:0] IDX_CTRL1      = 8'h1B;
    localparam logic [7:0] IDX_LED        = 8'h1C;

    // ==========================================================
    // field positions inside the stored words
    // ==========================================================
    localparam int AER_VER_LSB   = 13;
    localparam int CACHE_BIT     = 12;
    localparam int CAPV_LSB      = 10;
    localparam int MPS_LSB       = 8;
    localparam int ASPM_LSB      = 2;
    localparam int SLOTCLK_BIT   = 1;
    localparam int VMSG_BIT      = 11;
    localparam int NOSR_BIT      = 10;
    localparam int LED_BLINK_BIT = 7;
    localparam int LED_INV_BIT   = 6;
    localparam int LED_MODE_LSB  = 0;

    // ==========================================================
    // control register bit positions
    // ==========================================================
    localparam int CTRL_RELOAD_BIT   = 0;
    localparam int CTRL_DEFAULTS_BIT = 1;

    // ==========================================================
    // values after reset and counts
    // ==========================================================
    localparam logic [15:0] DEF_INIT3  = 16'h4A0E;
    localparam logic [15:0] DEF_CTRL1  = 16'h0400;
    localparam logic [15:0] DEF_LED    = 16'h0084;
    localparam logic [7:0]  CACHE_64   = 8'h40;
    localparam logic [7:0]  CACHE_128  = 8'h80;
    localparam logic [7:0]  NVM_TMO_CYCLES = 8'hFF;

    typedef struct packed {
        logic [2:0] aer_cap_version;
        logic [7:0] cache_line_bytes;
        logic [1:0] capability_version_field;
        logic [2:0] max_payload_supported;
        logic [1:0] aspm_support_field;
        logic       slot_clock_sel;
        logic       vendor_msg_check_off;
        logic       no_soft_reset;
        logic       activity_led_blink;
        logic       activity_led_invert;
        logic [3:0] activity_led_display_select;
    } pldl_cfg_type;

    localparam pldl_cfg_type CFG_RESET = '{3'h2, 8'h40, 2'h2, 3'h2, 2'h3, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 4'h4};

    typedef struct packed {
        logic        valid;
        logic        err;
        logic [15:0] data;
    } pldl_nvm_rsp_type;

    typedef enum logic [2:0] {
        ST_REQ  = 3'h1,
        ST_WAIT = 3'h2,
        ST_DONE = 3'h4
    } pldl_state_type;

endpackage

// File: pldl_word_decode.sv
`timescale 1ns/10ps
module pldl_word_decode (
    input  logic [15:0]          init3_i,  // pcie_init_word_three
    input  logic [15:0]          ctrl1_i,  // pcie_control_word_one
    input  logic [15:0]          led_i,    // activity_led_defaults_word
    output pldl_pkg::pldl_cfg_type cfg_o   // decoded fields
);
    import pldl_pkg::*;

    assign cfg_o.aer_cap_version             = init3_i[AER_VER_LSB +: 3];
    assign cfg_o.cache_line_bytes            = init3_i[CACHE_BIT] ? CACHE_128 : CACHE_64;
    assign cfg_o.capability_version_field    = init3_i[CAPV_LSB +: 2];
    // upper bit of the supported-size field is not stored, so always zero
    assign cfg_o.max_payload_supported       = {1'b0, init3_i[MPS_LSB +: 2]};
    assign cfg_o.aspm_support_field          = init3_i[ASPM_LSB +: 2];
    assign cfg_o.slot_clock_sel              = init3_i[SLOTCLK_BIT];
    assign cfg_o.vendor_msg_check_off        = ctrl1_i[VMSG_BIT];
    assign cfg_o.no_soft_reset               = ctrl1_i[NOSR_BIT];
    assign cfg_o.activity_led_blink          = led_i[LED_BLINK_BIT];
    assign cfg_o.activity_led_invert         = led_i[LED_INV_BIT];
    assign cfg_o.activity_led_display_select = led_i[LED_MODE_LSB +: 4];

endmodule

// File: pldl_loader_assertions.sv
`timescale 1ns/10ps
module pldl_loader_assertions (
    input wire logic                   ref_clk_i,     // clock
    input wire logic                   resetn_i,      // sync reset
    input wire logic                   ce_i,          // clock enable
    input wire logic                   wb_cyc_i,      // cycle
    input wire logic                   wb_stb_i,      // strobe
    input wire logic                   wb_we_i,       // write
    input wire logic [31:0]            wb_dat_o,      // read data
    input wire logic                   wb_ack_o,      // ack
    input wire logic [7:0]             nvm_addr_o,    // word address
    input wire logic                   nvm_rd_o,      // read pulse
    input wire logic                   d3hot_to_d0_i, // power change
    input wire logic                   soft_reset_o,  // reset pulse
    input wire pldl_pkg::pldl_cfg_type cfg_o,         // fields
    input wire logic                   load_done_o    // loaded
);
    import pldl_pkg::*;
    // ==========================================================
    // bus, store link and loaded fields
    // ==========================================================
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    AST_WR_ACK: assert property (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && ce_i |=> wb_ack_o)
        else $error("write not acked next cycle");
    AST_RD_PULSE: assert property (nvm_rd_o |=> !nvm_rd_o ##1 !nvm_rd_o)
        else $error("store read pulse too long");
    AST_RD_ADDR: assert property (nvm_rd_o |-> nvm_addr_o inside {8'h1A, 8'h1B, 8'h1C})
        else $error("store read outside the three words");
    AST_NO_RD_DONE: assert property (load_done_o |-> !nvm_rd_o)
        else $error("store read after load finished");
    AST_CFG_HOLD: assert property (!load_done_o |=> $stable(cfg_o) || load_done_o)
        else $error("fields changed in mid load");
    AST_CACHE: assert property (cfg_o.cache_line_bytes inside {8'h40, 8'h80})
        else $error("cache line not 64 or 128");
    AST_MPS_TOP: assert property (cfg_o.max_payload_supported[2] == 1'b0)
        else $error("payload top bit set");
    AST_SRST: assert property (d3hot_to_d0_i && ce_i && !cfg_o.no_soft_reset |=> soft_reset_o)
        else $error("no soft reset on wake");
    AST_NO_SRST: assert property (soft_reset_o |-> $past(d3hot_to_d0_i) && !$past(cfg_o.no_soft_reset))
        else $error("soft reset without cause");
endmodule

bind pldl_loader pldl_loader_assertions pldl_loader_assertions_i (.ref_clk_i, .resetn_i, .ce_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .nvm_addr_o, .nvm_rd_o, .d3hot_to_d0_i, .soft_reset_o, .cfg_o,
    .load_done_o);

// File: pldl_store_model.sv
`timescale 1ns/10ps
module pldl_store_model (
    input  logic                        ref_clk_i,  // clock
    input  logic [7:0]                  nvm_addr_i, // word address
    input  logic                        nvm_rd_i,   // read pulse
    input  logic [47:0]                 words_i,    // words 0x1C..0x1A
    input  logic [2:0]                  err_i,      // bad word flags
    input  logic [2:0]                  mute_i,     // never answer
    input  logic [3:0]                  delay_i,    // answer latency
    output pldl_pkg::pldl_nvm_rsp_type  rsp_o       // answer
);
    import pldl_pkg::*;
    // ==========================================================
    // word store
    // ==========================================================
    logic [3:0] cnt_r;
    logic       busy_r;
    logic [1:0] idx_r;
    wire  [7:0] off = nvm_addr_i - NVM_WORD_BASE;
    initial begin
        rsp_o  = '0;
        busy_r = 1'b0;
    end
    // idle lines toggle so a stale word never passes for an answer
    always @(posedge ref_clk_i) begin
        rsp_o.valid <= 1'b0;
        rsp_o.err   <= ~rsp_o.err;
        rsp_o.data  <= ~rsp_o.data;
        if (nvm_rd_i) begin
            idx_r  <= off[1:0];
            busy_r <= !mute_i[off[1:0]];
            cnt_r  <= delay_i;
        end else if (busy_r && cnt_r == 4'h0) begin
            // words pass untouched, the programmer owns their contents
            rsp_o.valid <= 1'b1;
            rsp_o.err   <= err_i[idx_r];
            rsp_o.data  <= words_i[idx_r*16 +: 16];
            busy_r      <= 1'b0;
        end else if (busy_r) begin
            cnt_r <= cnt_r - 4'h1;
        end
    end
endmodule

// File: pldl_loader_test.sv
`timescale 1ns/10ps
module pldl_loader_test;
    import pldl_pkg::*;
    logic             clk, rstn, cyc, stb, we, d3, ack, nvm_rd, srst, done;
    logic [7:0]       adr, nvm_addr;
    logic [3:0]       sel, mdly;
    logic [31:0]      wdat, rdat;
    logic [47:0]      mw;
    logic [63:0]      rnd;
    logic [2:0]       merr, mmute;
    logic [15:0]      e [3];
    logic [15:0]      dw [3];
    logic [31:0]      q [$];
    pldl_nvm_rsp_type rsp;
    pldl_cfg_type     cfg;
    int               n_errors, total_checks, seed, cyc_cnt, i, k;

    pldl_loader pldl_loader_i (.ref_clk_i(clk), .resetn_i(rstn), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .nvm_addr_o(nvm_addr), .nvm_rd_o(nvm_rd), .nvm_rsp_i(rsp), .d3hot_to_d0_i(d3), .soft_reset_o(srst),
        .cfg_o(cfg), .load_done_o(done));
    pldl_store_model pldl_store_model_i (.ref_clk_i(clk), .nvm_addr_i(nvm_addr), .nvm_rd_i(nvm_rd),
        .words_i(mw), .err_i(merr), .mute_i(mmute), .delay_i(mdly), .rsp_o(rsp));

    // ==========================================================
    // helpers
    // ==========================================================
    always #20 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    function automatic logic [31:0] exp_cfg(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        pldl_cfg_type x;
        x = '{a[15:13], a[12] ? 8'h80 : 8'h40, a[11:10], {1'b0, a[9:8]}, a[3:2], a[1], b[11], b[10],
              c[7], c[6], c[3:0]};
        return {5'h00, x};
    endfunction

    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp);
        q.push_back(exp);
        bus(1'b0, a, 32'h0);
    endtask

    task verify(input logic [31:0] st);
        rd(8'h08, exp_cfg(e[0], e[1], e[2]));
        for (k = 0; k < 3; k++)
            rd(8'h68 + 8'(4*k), {16'h0000, e[k]});
        rd(8'h04, st);
        @(posedge clk);
        d3 <= 1'b1;
        @(posedge clk);
        d3 <= 1'b0;
        @(negedge clk);
        check({31'h0, srst}, {31'h0, ~e[1][10]});
    endtask

    // reads are compared in order as their acks appear
    always @(posedge clk) begin
        cyc_cnt++;
        if (ack === 1'b1 && we === 1'b0)
            check(rdat, (q.size() != 0) ? q.pop_front() : ~rdat);
        if (cyc_cnt == 6000) begin
            n_errors++;
            wrap_up;
        end
    end

    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        clk = 1'b0; rstn = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; d3 = 1'b0;
        adr = 8'h00; sel = 4'hF; wdat = 32'h0; seed = 58; cyc_cnt = 0;
        dw = '{DEF_INIT3, DEF_CTRL1, DEF_LED};
        rnd = {$random(seed), $random(seed)};
        mw = rnd[47:0]; merr = 3'h0; mmute = 3'h0; mdly = 4'h3;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        check({5'h00, cfg}, {5'h00, CFG_RESET});
        check({31'h0, done}, 32'h0);
        rd(8'h40, 32'h0);
        bus(1'b1, 8'h68, 32'h0000FFFF);
        for (k = 0; k < 3; k++)
            e[k] = mw[16*k +: 16];
        verify(32'h00000001);
        $display("test reset load finished");
        // loads 4..6 cover a bad word, a silent word and the skip-store mode
        for (i = 0; i < 7; i++) begin
            rnd   = {$random(seed), $random(seed)};
            mw    <= rnd[47:0];
            mdly  <= rnd[51:48];
            merr  <= (i == 4) ? 3'b010 : 3'b000;
            mmute <= (i == 5) ? 3'b001 : 3'b000;
            bus(1'b1, 8'h00, {30'h0, i == 6, 1'b1});
            for (k = 0; k < 3; k++)
                e[k] = (merr[k] || mmute[k] || i == 6) ? dw[k] : rnd[16*k +: 16];
            verify({27'h0, merr | mmute, 2'b01});
            $display("test load %0d finished", i);
        end
        wrap_up;
    end
endmodule
